// ===== logic/sonet_frame_align_deserializer_port.sv
// receive framing, byte alignment, deserializer and transmit byte port
//
// The AHB-Lite slave port and the register addresses were chosen for this implementation.
module sonet_frame_align_deserializer_port (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  input wire logic rx_bit_valid,
  input wire logic rx_serial_bit,
  input wire logic frame_search_request,
  input wire logic internal_loss_detect_disable,
  input wire logic external_signal_loss_n,
  output logic [7:0] rx_byte_out,
  output logic rx_byte_clock,
  output logic frame_boundary_pulse,
  input wire logic tx_bit_tick,
  input wire logic [7:0] tx_byte_in,
  output logic tx_byte_clock,
  output logic [7:0] tx_byte_captured
);
  // bus side state
  logic [1:0] ctrl_q;
  logic [2:0] irq_status_q;
  logic [2:0] irq_status_d;
  logic [2:0] irq_mask_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] hrdata_q;
  logic irq_q;
  logic hready_q;
  // receive state
  logic [47:0] shift_q;
  logic [47:0] shift_d;
  logic [2:0] bit_cnt_q;
  logic aligned_q;
  logic [7:0] rx_byte_q;
  logic rx_clk_q;
  logic pulse_q;
  logic loss_prev_q;
  // transmit state
  logic [2:0] tx_cnt_q;
  logic tx_clk_q;
  logic [7:0] tx_hold_q;

  logic int_loss;
  logic loss_now;
  logic mute;
  logic match;
  logic found;
  logic byte_done;
  logic clk_rise;
  logic tx_wrap;
  logic addr_phase;
  logic rd_take;
  logic wr_take;
  logic rd_irq;
  logic [7:0] take_addr;
  logic [31:0] rd_value;
  logic [2:0] irq_events;

  loss_detector u_loss (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .bit_valid(rx_bit_valid),
    .bit_in(rx_serial_bit),
    .detect_disable(internal_loss_detect_disable),
    .loss_q(int_loss)
  );

  // external loss pin acts even with internal detection running
  assign loss_now = int_loss | ~external_signal_loss_n;
  assign mute = loss_now | ctrl_q[frame_align_pkg::ctrl_force_mute_bit];

  // newest bit enters at the bottom, so older bits sit higher
  assign shift_d = {shift_q[46:0], rx_serial_bit};
  assign match = shift_d == frame_align_pkg::frame_pattern;
  assign found = rx_bit_valid & frame_search_request & match;
  // a match closes the third a2 byte and restarts the bit count
  assign byte_done = rx_bit_valid &
    (found | (bit_cnt_q == frame_align_pkg::bits_last));
  assign clk_rise = rx_bit_valid & ~found &
    (bit_cnt_q == frame_align_pkg::clock_rise_bit);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      shift_q <= '0;
      bit_cnt_q <= 3'h0;
      aligned_q <= 1'b0;
    end
    else if (clk_en && rx_bit_valid)
    begin
      shift_q <= shift_d;
      // boundary only moves while searching, otherwise it free runs
      bit_cnt_q <= found ? 3'h0 : bit_cnt_q + 3'h1;
      if (found)
        aligned_q <= 1'b1;
    end
  end

  // byte clock: low for the first half of each byte, falls at completion
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_clk_q <= 1'b0;
      rx_byte_q <= 8'h00;
      pulse_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (byte_done)
      begin
        rx_clk_q <= 1'b0;
        rx_byte_q <= mute ? 8'h00 : shift_d[7:0];
        pulse_q <= found;
      end
      else if (clk_rise)
        rx_clk_q <= 1'b1;
      else if (mute)
        rx_byte_q <= 8'h00;
    end
  end

  // transmit divider: clock rises on the wrap, byte captured there too
  assign tx_wrap = tx_bit_tick & (tx_cnt_q == frame_align_pkg::bits_last);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_cnt_q <= 3'h0;
      tx_clk_q <= 1'b0;
      tx_hold_q <= 8'h00;
    end
    else if (clk_en && tx_bit_tick)
    begin
      tx_cnt_q <= tx_cnt_q + 3'h1;
      // only a wrap raises the clock, so no rise goes by without a capture
      tx_clk_q <= tx_wrap |
        (tx_clk_q & (tx_cnt_q < frame_align_pkg::clock_rise_bit));
      // framer drives its data from our byte clock, so it is stable here
      if (tx_wrap)
        tx_hold_q <= tx_byte_in;
    end
  end

  // bus slave: zero wait, read data registered in the address phase
  assign addr_phase = hsel & hready & htrans[1];
  assign rd_take = addr_phase & ~hwrite;
  assign wr_take = addr_phase & hwrite;
  assign take_addr = haddr[7:0];
  assign rd_irq = rd_take & (take_addr == frame_align_pkg::irq_status_offset);

  always_comb
  begin
    rd_value = 32'h0000_0000;
    case (take_addr)
      frame_align_pkg::ctrl_offset:
        rd_value = {30'h0, ctrl_q};
      frame_align_pkg::status_offset:
      begin
        rd_value[frame_align_pkg::stat_loss_bit] = loss_now;
        rd_value[frame_align_pkg::stat_search_bit] = frame_search_request;
        rd_value[frame_align_pkg::stat_aligned_bit] = aligned_q;
        rd_value[frame_align_pkg::stat_internal_loss_bit] = int_loss;
        rd_value[frame_align_pkg::stat_rate_high_bit] =
          ctrl_q[frame_align_pkg::ctrl_rate_high_bit];
      end
      frame_align_pkg::irq_status_offset:
        rd_value = {29'h0, irq_status_q};
      frame_align_pkg::irq_mask_offset:
        rd_value = {29'h0, irq_mask_q};
      frame_align_pkg::rx_last_offset:
        rd_value = {24'h0, rx_byte_q};
      frame_align_pkg::tx_last_offset:
        rd_value = {24'h0, tx_hold_q};
      default:
        rd_value = 32'h0000_0000;
    endcase
  end

  assign irq_events[frame_align_pkg::irq_frame_bit] = found & byte_done;
  assign irq_events[frame_align_pkg::irq_loss_set_bit] =
    loss_now & ~loss_prev_q;
  assign irq_events[frame_align_pkg::irq_loss_clear_bit] =
    ~loss_now & loss_prev_q;
  // a new event wins over the read that clears the register
  assign irq_status_d = (rd_irq ? 3'h0 : irq_status_q) | irq_events;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q <= frame_align_pkg::ctrl_reset;
      irq_mask_q <= frame_align_pkg::irq_mask_reset;
      irq_status_q <= 3'h0;
      loss_prev_q <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
      irq_q <= 1'b0;
      hready_q <= 1'b0;
    end
    else if (clk_en)
    begin
      hready_q <= 1'b1;
      loss_prev_q <= loss_now;
      irq_status_q <= irq_status_d;
      irq_q <= |(irq_status_d & irq_mask_q);
      wr_pend_q <= wr_take;
      wr_addr_q <= take_addr;
      if (rd_take)
        hrdata_q <= rd_value;
      if (wr_pend_q && wr_addr_q == frame_align_pkg::ctrl_offset)
        ctrl_q <= hwdata[1:0];
      if (wr_pend_q && wr_addr_q == frame_align_pkg::irq_mask_offset)
        irq_mask_q <= hwdata[2:0];
    end
  end

  assign hrdata = hrdata_q;
  // ready from the first enabled cycle after reset, always okay: every access finishes in its first data cycle
  assign hreadyout = hready_q;
  assign hresp = 1'b0;
  assign irq = irq_q;
  assign rx_byte_out = rx_byte_q;
  assign rx_byte_clock = rx_clk_q;
  assign frame_boundary_pulse = pulse_q;
  assign tx_byte_clock = tx_clk_q;
  assign tx_byte_captured = tx_hold_q;
endmodule

// ===== logic/frame_align_pkg.sv
// shared constants for the frame aligner, deserializer and bus registers
package frame_align_pkg;
  // bus register byte offsets
  localparam logic [7:0] ctrl_offset = 8'h00;
  localparam logic [7:0] status_offset = 8'h04;
  localparam logic [7:0] irq_status_offset = 8'h08;
  localparam logic [7:0] irq_mask_offset = 8'h0c;
  localparam logic [7:0] rx_last_offset = 8'h10;
  localparam logic [7:0] tx_last_offset = 8'h14;
  // reset values
  localparam logic [1:0] ctrl_reset = 2'h0;
  localparam logic [2:0] irq_mask_reset = 3'h0;
  // control fields
  localparam int ctrl_rate_high_bit = 0;
  localparam int ctrl_force_mute_bit = 1;
  // status fields
  localparam int stat_loss_bit = 0;
  localparam int stat_search_bit = 1;
  localparam int stat_aligned_bit = 2;
  localparam int stat_internal_loss_bit = 3;
  localparam int stat_rate_high_bit = 4;
  // interrupt fields
  localparam int irq_frame_bit = 0;
  localparam int irq_loss_set_bit = 1;
  localparam int irq_loss_clear_bit = 2;
  localparam int irq_width = 3;
  // framing pattern
  localparam logic [7:0] a1_byte = 8'hf6;
  localparam logic [7:0] a2_byte = 8'h28;
  localparam logic [47:0] frame_pattern =
    {a1_byte, a1_byte, a1_byte, a2_byte, a2_byte, a2_byte};
  // byte assembly
  localparam logic [2:0] bits_last = 3'h7;
  localparam logic [2:0] clock_rise_bit = 3'h3;
  // loss of signal detector
  localparam logic [7:0] los_quiet_limit = 8'h80;
  localparam logic [7:0] los_clear_transitions = 8'h10;
  localparam int los_window_bits = 128;
endpackage

// ===== logic/loss_detector.sv
// transition based loss of signal detector on the serial bit stream
module loss_detector (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic bit_valid,
  input wire logic bit_in,
  input wire logic detect_disable,
  output logic loss_q
);
  logic prev_bit_q;
  logic have_prev_q;
  logic [7:0] quiet_q;
  logic [7:0] quiet_d;
  logic [frame_align_pkg::los_window_bits-1:0] hist_q;
  logic [7:0] trans_cnt_q;
  logic [7:0] trans_cnt_d;
  logic edge_now;
  logic oldest;
  logic declare;
  logic release_ok;

  assign edge_now = have_prev_q & (bit_in != prev_bit_q);
  assign oldest = hist_q[frame_align_pkg::los_window_bits-1];
  // counter saturates one past the limit: more than 128 quiet bits
  assign quiet_d = edge_now ? 8'h00 :
    (quiet_q > frame_align_pkg::los_quiet_limit) ? quiet_q :
    quiet_q + 8'h01;
  // sliding window count: add newest, drop oldest
  assign trans_cnt_d = trans_cnt_q + {7'h00, edge_now} - {7'h00, oldest};
  assign declare = quiet_d > frame_align_pkg::los_quiet_limit;
  assign release_ok =
    trans_cnt_d >= frame_align_pkg::los_clear_transitions;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prev_bit_q <= 1'b0;
      have_prev_q <= 1'b0;
      quiet_q <= 8'h00;
      hist_q <= '0;
      trans_cnt_q <= 8'h00;
      loss_q <= 1'b0;
    end
    else if (clk_en && bit_valid)
    begin
      prev_bit_q <= bit_in;
      have_prev_q <= 1'b1;
      quiet_q <= quiet_d;
      hist_q <= {hist_q[frame_align_pkg::los_window_bits-2:0], edge_now};
      trans_cnt_q <= trans_cnt_d;
      if (detect_disable)
        loss_q <= 1'b0;
      else if (declare)
        loss_q <= 1'b1;
      else if (loss_q && release_ok)
        loss_q <= 1'b0;
    end
    else if (clk_en && detect_disable)
    begin
      loss_q <= 1'b0;
    end
  end
endmodule

// ===== sim/frame_align_properties.sv
// checker on the frame aligner top module ports
module frame_align_properties (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tx_bit_tick,
  input wire logic frame_search_request,
  input wire logic internal_loss_detect_disable,
  input wire logic external_signal_loss_n,
  input wire logic [7:0] rx_byte_out,
  input wire logic rx_byte_clock,
  input wire logic frame_boundary_pulse,
  input wire logic [7:0] tx_byte_in,
  input wire logic tx_byte_clock,
  input wire logic [7:0] tx_byte_captured
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_pulse_search: assert property (
    $rose(frame_boundary_pulse) |-> $past(frame_search_request))
    else $error("pulse without search request");
  a_pulse_a2: assert property (
    $rose(frame_boundary_pulse) && external_signal_loss_n
    |-> rx_byte_out == frame_align_pkg::a2_byte)
    else $error("pulse not on the third a2 byte");
  a_pulse_period: assert property (
    $changed(frame_boundary_pulse) && external_signal_loss_n
    |-> !rx_byte_clock)
    else $error("pulse edge off the byte boundary");
  a_ext_mute: assert property (
    !external_signal_loss_n [*3] |-> rx_byte_out == 8'h00)
    else $error("output not muted on external loss");
  a_rise_stable: assert property (
    $rose(rx_byte_clock) && internal_loss_detect_disable
    && external_signal_loss_n && $past(external_signal_loss_n)
    |-> $stable(rx_byte_out))
    else $error("byte changed at rising byte clock");
  a_tx_capture: assert property (
    $rose(tx_byte_clock) |-> tx_byte_captured == $past(tx_byte_in))
    else $error("tx byte not captured at clock rise");
  a_tx_hold: assert property (
    !$rose(tx_byte_clock) |-> $stable(tx_byte_captured))
    else $error("tx capture changed between rises");
  a_tx_divide: assert property (
    $changed(tx_byte_clock) |-> $past(tx_bit_tick))
    else $error("tx byte clock moved without a tick");
endmodule

bind sonet_frame_align_deserializer_port frame_align_properties i_props (
  .hclk, .hresetn, .tx_bit_tick, .frame_search_request,
  .internal_loss_detect_disable, .external_signal_loss_n,
  .rx_byte_out, .rx_byte_clock, .frame_boundary_pulse,
  .tx_byte_in, .tx_byte_clock, .tx_byte_captured);

// ===== sim/framer_model.sv
// framer model: transmit bytes timed from tx_byte_clock
module framer_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tx_byte_clock,
  output logic [7:0] tx_byte_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_was_q;
  // new byte after the fall, settled long before the capturing rise
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      clk_was_q <= 1'b0;
      tx_byte_in <= 8'h00;
    end
    else
    begin
      clk_was_q <= tx_byte_clock;
      if (clk_was_q && !tx_byte_clock)
        tx_byte_in <= tx_byte_in + 8'h11;
    end
endmodule

// ===== sim/sonet_frame_align_deserializer_port_tb.sv
// self-checking bench for the frame aligner and byte ports
`define check(n, e, g) \
  begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module sonet_frame_align_deserializer_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic rx_bit_valid = 1'b0;
  logic rx_serial_bit = 1'b0;
  logic frame_search_request = 1'b0;
  logic internal_loss_detect_disable = 1'b1;
  logic external_signal_loss_n = 1'b1;
  logic tx_bit_tick = 1'b0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, irq, rx_byte_clock, frame_boundary_pulse;
  logic tx_byte_clock, tx_clk_was;
  logic [7:0] rx_byte_out, tx_byte_in, tx_byte_captured;
  int fail_count = 0;
  int checks = 0;
  int pulse_cycles = 0;
  int tx_rises = 0;
  always #50 hclk = ~hclk;
  always @(posedge hclk)
  begin
    pulse_cycles <= pulse_cycles + int'(frame_boundary_pulse);
    tx_clk_was <= tx_byte_clock;
    tx_rises <= tx_rises + int'(tx_byte_clock && !tx_clk_was);
  end
  sonet_frame_align_deserializer_port i_dut (
    .hclk, .hresetn, .clk_en(1'b1), .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .irq, .rx_bit_valid, .rx_serial_bit, .frame_search_request,
    .internal_loss_detect_disable, .external_signal_loss_n,
    .rx_byte_out, .rx_byte_clock, .frame_boundary_pulse, .tx_bit_tick,
    .tx_byte_in, .tx_byte_clock, .tx_byte_captured);
  framer_model i_framer (.hclk, .hresetn, .tx_byte_clock, .tx_byte_in);
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic send_word(input logic [63:0] v);
    for (int i = 63; i >= 0; i--)
    begin
      @(posedge hclk);
      rx_bit_valid <= 1'b1;
      rx_serial_bit <= v[i];
    end
    @(posedge hclk);
    rx_bit_valid <= 1'b0;
    #1;
  endtask
  task automatic status_loss(input logic e);
    ahb(1'b0, frame_align_pkg::status_offset, 32'h0);
    `check("loss", e, rd[frame_align_pkg::stat_loss_bit])
  endtask
  task automatic t_regs;
    ahb(1'b0, frame_align_pkg::irq_mask_offset, 32'h0);
    `check("mask", 32'h0, rd)
    ahb(1'b0, 8'h20, 32'h0);
    `check("unmapped", 32'h0, rd)
  endtask
  task automatic t_align;
    frame_search_request <= 1'b1;
    send_word({5'h0b, 3'h5, frame_align_pkg::frame_pattern, 8'h5a});
    `check("rx byte", 8'h5a, rx_byte_out)
    `check("pulse", 8, pulse_cycles)
    ahb(1'b0, frame_align_pkg::irq_status_offset, 32'h0);
    `check("frame event", 32'h1, rd)
    frame_search_request <= 1'b0;
  endtask
  task automatic t_lock;
    // pattern three bits off the held boundary must be ignored
    send_word({3'h5, frame_align_pkg::frame_pattern, 13'h00c3});
    `check("held byte", 8'hc3, rx_byte_out)
    `check("no pulse", 8, pulse_cycles)
    ahb(1'b1, frame_align_pkg::ctrl_offset, 32'h2);
    ahb(1'b0, frame_align_pkg::ctrl_offset, 32'h0);
    `check("ctrl", 32'h2, rd)
    `check("forced mute", 8'h00, rx_byte_out)
    ahb(1'b1, frame_align_pkg::ctrl_offset, 32'h0);
  endtask
  task automatic t_mute;
    external_signal_loss_n <= 1'b0;
    repeat (4) @(posedge hclk);
    #1;
    `check("muted", 8'h00, rx_byte_out)
    `check("masked", 1'b0, irq)
    ahb(1'b1, frame_align_pkg::irq_mask_offset, 32'h2);
    repeat (2) @(posedge hclk);
    `check("irq", 1'b1, irq)
    ahb(1'b0, frame_align_pkg::irq_status_offset, 32'h0);
    `check("loss event", 32'h2, rd)
    repeat (2) @(posedge hclk);
    `check("irq clear", 1'b0, irq)
    external_signal_loss_n <= 1'b1;
    send_word(64'h81);
    `check("unmuted", 8'h81, rx_byte_out)
  endtask
  task automatic t_internal;
    internal_loss_detect_disable <= 1'b0;
    send_word(64'h0);
    status_loss(1'b0);
    send_word(64'h0);
    send_word(64'h0);
    status_loss(1'b1);
    send_word(64'h5555_5555_5555_5555);
    status_loss(1'b0);
    internal_loss_detect_disable <= 1'b1;
    repeat (3) send_word(64'h0);
    status_loss(1'b0);
  endtask
  task automatic t_tx;
    repeat (32)
    begin
      @(posedge hclk);
      tx_bit_tick <= 1'b1;
      @(posedge hclk);
      tx_bit_tick <= 1'b0;
    end
    ahb(1'b0, frame_align_pkg::tx_last_offset, 32'h0);
    `check("tx last", 32'h33, rd)
    `check("tx rises", 4, tx_rises)
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_align();
    t_lock();
    t_mute();
    t_internal();
    t_tx();
    tally_and_finish();
  end
  initial
  begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    tally_and_finish();
  end
endmodule
